// ==== hdl/ddr_timing_pkg.sv ====
// package: pin codes, mode fields and command spacings for the ddr module host
package ddr_timing_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 8;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int ADDR_W = 13;
  localparam int RD_PIPE_W = 16;

  // ----------------------------------------------------------------
  // spacings in clock cycles
  // ----------------------------------------------------------------
  localparam int WRITE_TO_PRECHARGE_BASE = 3;
  localparam int WRITE_TO_READ_BASE = 2;
  localparam int BURST_STOP_TO_WRITE_CL2 = 2;
  localparam int BURST_STOP_TO_WRITE_CL25 = 3;
  localparam int READ_TO_WRITE_BASE_CL2 = 2;
  localparam int READ_TO_WRITE_BASE_CL25 = 3;
  localparam int WRITE_DATA_LATENCY = 1;
  localparam int MASK_LATENCY = 0;
  localparam int MODE_SET_GAP = 2;
  localparam int SELFREFRESH_EXIT_NONREAD_GAP = 10;
  localparam int SELFREFRESH_EXIT_READ_GAP = 200;
  localparam int POWERDOWN_EXIT_GAP = 1;
  localparam int CLOCK_ENABLE_MIN_PULSE = 1;
  // read data capture, half cycle of cas latency 2.5 rounded up
  localparam int READ_CAPTURE_CL2 = 2;
  localparam int READ_CAPTURE_CL25 = 3;

  // ----------------------------------------------------------------
  // mode register fields and reset values
  // ----------------------------------------------------------------
  localparam int BL_LSB = 0;
  localparam int CL_LSB = 4;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_CODE_2 = 3'h2;
  localparam logic [2:0] CL_CODE_25 = 3'h6;
  localparam logic [3:0] BL_HALF_RESET = 4'h4;
  localparam logic CL25_RESET = 1'b1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_BST, OP_MRS, OP_REF,
    OP_SREF_IN, OP_PDOWN_IN, OP_LP_EXIT
  } op_t;

  typedef enum logic [1:0] {ST_RUN, ST_PDOWN, ST_SREF} pwr_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } pins_t;

  typedef struct packed {
    op_t op;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } user_cmd_t;

  localparam pins_t PINS_NOP = 4'h7;
  localparam pins_t PINS_ACT = 4'h3;
  localparam pins_t PINS_READ = 4'h5;
  localparam pins_t PINS_WRITE = 4'h4;
  localparam pins_t PINS_PRE = 4'h2;
  localparam pins_t PINS_BST = 4'h6;
  localparam pins_t PINS_MRS = 4'h0;
  localparam pins_t PINS_REF = 4'h1;

  function automatic logic [CNT_W-1:0] gap_load(input int n);
    return CNT_W'(n - 1);
  endfunction

  function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] c);
    return (c == '0) ? c : c - CNT_W'(1);
  endfunction

  function automatic pins_t op_pins(input op_t op);
    case (op)
      OP_ACT: return PINS_ACT;
      OP_READ: return PINS_READ;
      OP_WRITE: return PINS_WRITE;
      OP_PRE: return PINS_PRE;
      OP_BST: return PINS_BST;
      OP_MRS: return PINS_MRS;
      OP_REF, OP_SREF_IN: return PINS_REF;
      default: return PINS_NOP;
    endcase
  endfunction

endpackage

// ==== hdl/wbuf2.sv ====
// two-entry valid/ready buffer for write data beats
`timescale 1ns/10ps
`default_nettype none
module wbuf2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  if (WIDTH < 1) begin : g_bad_width
    $error("wbuf2: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic rdy;
  } buf_t;

  buf_t s_q;
  buf_t s_d;
  logic push;
  logic pop;

  always_comb begin
    s_d = s_q;
    push = in_valid_i && s_q.rdy;
    pop = out_ready_i && (s_q.cnt != 2'h0);
    if (push) begin
      s_d.mem[s_q.wp] = in_data_i;
      s_d.wp = ~s_q.wp;
    end
    if (pop) begin
      s_d.rp = ~s_q.rp;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    // ready registered so the source sees a flop, taken from the next count so both slots fill
    s_d.rdy = (s_d.cnt != 2'h2);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready_o = s_q.rdy;
  assign out_valid_o = (s_q.cnt != 2'h0);
  assign out_data_o = s_q.mem[s_q.rp];
endmodule
`default_nettype wire

// ==== hdl/ddr_cmd_host.sv ====
// host-side command spacer and data mover for an unbuffered ddr memory module
`timescale 1ns/10ps
`default_nettype none
module ddr_cmd_host
  import ddr_timing_pkg::*;
#(
  parameter int DQ_W = 64
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire user_cmd_t cmd_i,
  output logic cmd_ready_o,
  input wire logic wd_valid_i,
  input wire logic [2*DQ_W-1:0] wd_data_i,
  input wire logic [2*DQ_W/8-1:0] wd_mask_i,
  output logic wd_ready_o,
  output logic rd_valid_o,
  output logic [2*DQ_W-1:0] rd_data_o,
  output logic cke_o,
  output pins_t cmd_pins_o,
  output logic [BANK_W-1:0] ba_o,
  output logic [ADDR_W-1:0] addr_o,
  input wire logic [2*DQ_W-1:0] dq_i,
  output logic [2*DQ_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic [2*DQ_W/8-1:0] dm_o
);
  localparam int BEAT_W = 2 * DQ_W;
  localparam int MASK_W = BEAT_W / 8;

  if (DQ_W < 8 || (DQ_W % 8) != 0) begin : g_bad_dq
    $error("ddr_cmd_host: DQ_W must be a non-zero multiple of 8");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pwr_t pwr;
    logic pend_v;
    user_cmd_t pend;
    logic cmd_rdy;
    logic cke;
    pins_t pins;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [3:0] bl_half;
    logic cl25;
    logic [NBANK-1:0][CNT_W-1:0] pre_cnt;
    logic [CNT_W-1:0] wr_rd;
    logic [CNT_W-1:0] rd_wr;
    logic [CNT_W-1:0] bst_wr;
    logic [CNT_W-1:0] mrs;
    logic [CNT_W-1:0] nonrd;
    logic [CNT_W-1:0] rd_gate;
    logic [CNT_W-1:0] cke_hold;
    logic [3:0] wr_beats;
    logic [RD_PIPE_W-1:0] rd_pipe;
    logic [BEAT_W-1:0] dq;
    logic dq_oe;
    logic [MASK_W-1:0] dm;
    logic rd_v;
    logic [BEAT_W-1:0] rd_data;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic legal;
  logic fire;
  logic buf_valid;
  logic buf_pop;
  logic [BEAT_W+MASK_W-1:0] buf_data;
  int bh;
  int rd_to_wr;
  int bst_to_wr;
  int capture;

  // ----------------------------------------------------------------
  // write data buffer
  // ----------------------------------------------------------------
  assign buf_pop = (s_q.wr_beats != 4'h0);

  wbuf2 #(
    .WIDTH(BEAT_W + MASK_W)
  ) u_wbuf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(wd_valid_i),
    .in_ready_o(wd_ready_o),
    .in_data_i({wd_mask_i, wd_data_i}),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_data)
  );

  // ----------------------------------------------------------------
  // legality of the pending command
  // ----------------------------------------------------------------
  always_comb begin
    legal = 1'b0;
    if (s_q.pwr != ST_RUN) begin
      legal = (s_q.pend.op == OP_LP_EXIT) && (s_q.cke_hold == '0);
    end else begin
      case (s_q.pend.op)
        OP_ACT: legal = (s_q.mrs == '0) && (s_q.nonrd == '0);
        OP_READ: legal = (s_q.wr_rd == '0) && (s_q.rd_gate == '0);
        OP_WRITE: legal = (s_q.rd_wr == '0) && (s_q.bst_wr == '0)
          && (s_q.nonrd == '0) && (s_q.wr_beats <= 4'h1);
        OP_PRE: legal = (s_q.pre_cnt[s_q.pend.bank] == '0) && (s_q.nonrd == '0);
        OP_MRS: legal = (s_q.mrs == '0) && (s_q.nonrd == '0)
          && (s_q.wr_beats == 4'h0) && (s_q.rd_pipe == '0);
        OP_SREF_IN, OP_PDOWN_IN: legal = (s_q.nonrd == '0) && (s_q.cke_hold == '0)
          && (s_q.wr_beats == 4'h0) && (s_q.rd_pipe == '0);
        OP_LP_EXIT: legal = 1'b1;
        default: legal = (s_q.nonrd == '0);
      endcase
    end
    fire = s_q.pend_v && legal;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // spacings are always taken from the live mode fields
    bh = int'(s_q.bl_half);
    bst_to_wr = s_q.cl25 ? BURST_STOP_TO_WRITE_CL25 : BURST_STOP_TO_WRITE_CL2;
    rd_to_wr = (s_q.cl25 ? READ_TO_WRITE_BASE_CL25 : READ_TO_WRITE_BASE_CL2) + bh;
    capture = s_q.cl25 ? READ_CAPTURE_CL25 : READ_CAPTURE_CL2;
    for (int b = 0; b < NBANK; b++) begin
      s_d.pre_cnt[b] = count_down(s_q.pre_cnt[b]);
    end
    s_d.wr_rd = count_down(s_q.wr_rd);
    s_d.rd_wr = count_down(s_q.rd_wr);
    s_d.bst_wr = count_down(s_q.bst_wr);
    s_d.mrs = count_down(s_q.mrs);
    s_d.nonrd = count_down(s_q.nonrd);
    s_d.rd_gate = count_down(s_q.rd_gate);
    s_d.cke_hold = count_down(s_q.cke_hold);
    s_d.pins = PINS_NOP;
    s_d.rd_pipe = s_q.rd_pipe >> 1;

    if (fire) begin
      s_d.pend_v = 1'b0;
      s_d.pins = op_pins(s_q.pend.op);
      s_d.ba = s_q.pend.bank;
      s_d.addr = s_q.pend.addr;
      case (s_q.pend.op)
        OP_WRITE: begin
          s_d.pre_cnt[s_q.pend.bank] = gap_load(WRITE_TO_PRECHARGE_BASE + bh);
          s_d.wr_rd = gap_load(WRITE_TO_READ_BASE + bh);
          s_d.wr_beats = s_q.bl_half;
        end
        OP_READ: begin
          if (gap_load(bh) > s_d.pre_cnt[s_q.pend.bank]) begin
            s_d.pre_cnt[s_q.pend.bank] = gap_load(bh);
          end
          s_d.rd_wr = gap_load(rd_to_wr);
          s_d.rd_pipe = s_d.rd_pipe
            | ((((RD_PIPE_W)'(1) << s_q.bl_half) - (RD_PIPE_W)'(1)) << capture);
        end
        OP_BST: s_d.bst_wr = gap_load(bst_to_wr);
        OP_MRS: begin
          s_d.mrs = gap_load(MODE_SET_GAP);
          if (s_q.pend.bank == '0) begin
            case (s_q.pend.addr[BL_LSB +: 3])
              BL_CODE_2: s_d.bl_half = 4'h1;
              BL_CODE_4: s_d.bl_half = 4'h2;
              BL_CODE_8: s_d.bl_half = 4'h4;
              default: s_d.bl_half = s_q.bl_half;
            endcase
            case (s_q.pend.addr[CL_LSB +: 3])
              CL_CODE_2: s_d.cl25 = 1'b0;
              CL_CODE_25: s_d.cl25 = 1'b1;
              default: s_d.cl25 = s_q.cl25;
            endcase
          end
        end
        OP_SREF_IN, OP_PDOWN_IN: begin
          s_d.cke = 1'b0;
          s_d.cke_hold = gap_load(CLOCK_ENABLE_MIN_PULSE);
          s_d.pwr = (s_q.pend.op == OP_SREF_IN) ? ST_SREF : ST_PDOWN;
        end
        OP_LP_EXIT: begin
          if (s_q.pwr != ST_RUN) begin
            // exit cycle carries a nop, the next command waits out the gap
            s_d.cke = 1'b1;
            s_d.cke_hold = gap_load(CLOCK_ENABLE_MIN_PULSE);
            s_d.pwr = ST_RUN;
            if (s_q.pwr == ST_SREF) begin
              s_d.nonrd = gap_load(SELFREFRESH_EXIT_NONREAD_GAP);
              s_d.rd_gate = gap_load(SELFREFRESH_EXIT_READ_GAP);
            end else begin
              s_d.nonrd = gap_load(POWERDOWN_EXIT_GAP);
            end
          end
        end
        default: begin
        end
      endcase
    end

    // write beats: driven one cycle after the command reaches the pins
    s_d.dq_oe = 1'b0;
    s_d.dm = '1;
    if (s_q.wr_beats != 4'h0) begin
      s_d.wr_beats = s_q.wr_beats - 4'h1;
      if (fire && s_q.pend.op == OP_WRITE) begin
        s_d.wr_beats = s_q.bl_half;
      end
      s_d.dq_oe = 1'b1;
      s_d.dq = buf_data[BEAT_W-1:0];
      // an underrun beat goes out fully masked instead of stalling the burst
      s_d.dm = buf_valid ? buf_data[BEAT_W +: MASK_W] : '1;
    end

    // read capture relies on the module floating its outputs in time
    s_d.rd_v = s_q.rd_pipe[0];
    if (s_q.rd_pipe[0]) begin
      s_d.rd_data = dq_i;
    end

    if (s_q.cmd_rdy && cmd_valid_i) begin
      s_d.pend_v = 1'b1;
      s_d.pend = cmd_i;
    end
    s_d.cmd_rdy = !s_d.pend_v;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.pwr <= ST_RUN;
      s_q.cke <= 1'b1;
      s_q.cmd_rdy <= 1'b1;
      s_q.pins <= PINS_NOP;
      s_q.bl_half <= BL_HALF_RESET;
      s_q.cl25 <= CL25_RESET;
      s_q.dm <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmd_ready_o = s_q.cmd_rdy;
  assign rd_valid_o = s_q.rd_v;
  assign rd_data_o = s_q.rd_data;
  assign cke_o = s_q.cke;
  assign cmd_pins_o = s_q.pins;
  assign ba_o = s_q.ba;
  assign addr_o = s_q.addr;
  assign dq_o = s_q.dq;
  assign dq_oe_o = s_q.dq_oe;
  assign dm_o = s_q.dm;

  // ----------------------------------------------------------------
  // checks on the pins
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] since_wr, since_rd, since_bst, since_mrs, since_up;
  logic [BANK_W-1:0] wr_bank, rd_bank;
  logic cke_prev, from_sref, in_sref;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
    return (c == '1) ? c : c + CNT_W'(1);
  endfunction

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      since_wr <= '1;
      since_rd <= '1;
      since_bst <= '1;
      since_mrs <= '1;
      since_up <= '1;
      wr_bank <= '0;
      rd_bank <= '0;
      cke_prev <= 1'b1;
      from_sref <= 1'b0;
      in_sref <= 1'b0;
    end else begin
      since_wr <= (cmd_pins_o == PINS_WRITE) ? CNT_W'(1) : sat_inc(since_wr);
      since_rd <= (cmd_pins_o == PINS_READ) ? CNT_W'(1) : sat_inc(since_rd);
      since_bst <= (cmd_pins_o == PINS_BST) ? CNT_W'(1) : sat_inc(since_bst);
      since_mrs <= (cmd_pins_o == PINS_MRS) ? CNT_W'(1) : sat_inc(since_mrs);
      since_up <= (cke_o && !cke_prev) ? CNT_W'(1) : sat_inc(since_up);
      if (cmd_pins_o == PINS_WRITE) wr_bank <= ba_o;
      if (cmd_pins_o == PINS_READ) rd_bank <= ba_o;
      cke_prev <= cke_o;
      if (cmd_pins_o == PINS_REF && !cke_o) in_sref <= 1'b1;
      if (cke_o && !cke_prev) begin
        from_sref <= in_sref;
        in_sref <= 1'b0;
      end
    end
  end

  a_wr_to_pre: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_pins_o == PINS_PRE && ba_o == wr_bank)
      |-> int'(since_wr) >= WRITE_TO_PRECHARGE_BASE + int'(s_q.bl_half))
    else $error("precharge too soon after write");
  a_rd_to_pre: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_pins_o == PINS_PRE && ba_o == rd_bank) |-> int'(since_rd) >= int'(s_q.bl_half))
    else $error("precharge too soon after read");
  a_wr_to_rd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_pins_o == PINS_READ |-> int'(since_wr) >= WRITE_TO_READ_BASE + int'(s_q.bl_half))
    else $error("read too soon after write");
  a_bst_to_wr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_pins_o == PINS_WRITE
      |-> int'(since_bst) >= (s_q.cl25 ? BURST_STOP_TO_WRITE_CL25 : BURST_STOP_TO_WRITE_CL2))
    else $error("write too soon after burst stop");
  a_rd_to_wr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_pins_o == PINS_WRITE |-> int'(since_rd) >= int'(s_q.bl_half)
      + (s_q.cl25 ? READ_TO_WRITE_BASE_CL25 : READ_TO_WRITE_BASE_CL2))
    else $error("write too soon after read");
  a_wdata_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_pins_o == PINS_WRITE |=> dq_oe_o)
    else $error("write data not one cycle after write");
  a_mask_underrun: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (buf_pop && !buf_valid) |=> (dq_oe_o && dm_o == '1))
    else $error("missing beat not masked");
  a_mode_set_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_pins_o == PINS_ACT || cmd_pins_o == PINS_MRS) |-> int'(since_mrs) >= MODE_SET_GAP)
    else $error("activate or mode set too soon after mode set");
  a_sref_nonread: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (from_sref && cmd_pins_o != PINS_NOP && cmd_pins_o != PINS_READ)
      |-> int'(since_up) >= SELFREFRESH_EXIT_NONREAD_GAP)
    else $error("command too soon after self refresh exit");
  a_sref_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (from_sref && cmd_pins_o == PINS_READ) |-> int'(since_up) >= SELFREFRESH_EXIT_READ_GAP)
    else $error("read too soon after self refresh exit");
  a_pd_exit_nop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(cke_o) |-> cmd_pins_o == PINS_NOP)
    else $error("command presented on power down exit");
  a_mode_bl2: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_pins_o == PINS_MRS && ba_o == '0 && addr_o[BL_LSB +: 3] == BL_CODE_2)
      |-> s_q.bl_half == 4'h1)
    else $error("burst length not taken from mode set");

  c_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_pins_o == PINS_WRITE ##1 dq_oe_o);
  c_read: cover property (@(posedge clk_i) disable iff (!rst_n_i) rd_valid_o);
  c_sref_exit_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    from_sref && cmd_pins_o == PINS_READ);
endmodule
`default_nettype wire

// ==== verification/ddr_dimm_model.sv ====
// behavioural memory-module model that checks the host's command spacing
`timescale 1ns/10ps
`default_nettype none
module ddr_dimm_model
  import ddr_timing_pkg::*;
#(
  parameter int DQ_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cke_i,
  input wire pins_t pins_i,
  input wire logic [BANK_W-1:0] ba_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [2*DQ_W-1:0] bus_i,
  input wire logic oe_i,
  input wire logic [2*DQ_W/8-1:0] dm_i,
  output logic [2*DQ_W-1:0] dq_o,
  output logic seen_o,
  output logic [2*DQ_W-1:0] beat_o,
  output logic [2*DQ_W/8-1:0] mask_o,
  output int viol_o
);
  logic [7:0] wr_age, rd_age, stop_age, bst_age, mrs_age, sr_age, cke_age, cap, col;
  logic [3:0] half;
  logic lat25, sref, cke_q, drive;
  logic [BANK_W-1:0] wr_bank, rd_bank;
  logic [2*DQ_W-1:0] last_q;
  function automatic logic [7:0] up(input logic [7:0] a);
    return (a == 8'hFF) ? a : a + 8'h01;
  endfunction
  assign cap = lat25 ? 8'(READ_CAPTURE_CL25) : 8'(READ_CAPTURE_CL2);
  // a stopped burst keeps driving up to its float bound, then lets go
  assign drive = (rd_age + 8'h01 >= cap) && (rd_age + 8'h01 < cap + 8'(half))
    && (rd_age < stop_age);
  // released bus shows the inverse of the last level, never a stale copy
  assign dq_o = drive ? (2*DQ_W)'({col, 8'(rd_age + 8'h01 - cap)}) : ~last_q;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      {wr_age, rd_age, stop_age, bst_age, mrs_age, sr_age} <= '1;
      {cke_age, col, wr_bank, rd_bank, last_q} <= '0;
      half <= BL_HALF_RESET;
      lat25 <= CL25_RESET;
      {sref, seen_o} <= 2'h0;
      cke_q <= 1'b1;
      viol_o = 0;
    end else begin
      last_q <= bus_i;
      {wr_age, rd_age, bst_age} <= {up(wr_age), up(rd_age), up(bst_age)};
      {mrs_age, sr_age, cke_age} <= {up(mrs_age), up(sr_age), up(cke_age)};
      seen_o <= 1'b0;
      cke_q <= cke_i;
      if (cke_i != cke_q) begin
        cke_age <= 8'h00;
        if (cke_age < CLOCK_ENABLE_MIN_PULSE - 1) viol_o++;
        if (cke_i && sref) begin
          sr_age <= 8'h00;
          sref <= 1'b0;
        end
      end
      if (wr_age < 8'(half)) begin
        if (oe_i !== 1'b1) viol_o++;
        seen_o <= 1'b1;
        beat_o <= bus_i;
        mask_o <= dm_i;
      end
      if (pins_i != PINS_NOP) begin
        if (pins_i == PINS_REF && !cke_i && cke_q) sref <= 1'b1;
        else if (!cke_i || !cke_q) viol_o++;
        if (sr_age < SELFREFRESH_EXIT_NONREAD_GAP - 1) viol_o++;
        case (pins_i)
          PINS_MRS: begin
            if (mrs_age < MODE_SET_GAP - 1) viol_o++;
            mrs_age <= 8'h00;
            if (ba_i == '0 && addr_i[2:0] == BL_CODE_2) half <= 4'h1;
            if (ba_i == '0 && addr_i[2:0] == BL_CODE_4) half <= 4'h2;
            if (ba_i == '0 && addr_i[2:0] == BL_CODE_8) half <= 4'h4;
            if (ba_i == '0 && addr_i[6:4] == CL_CODE_2) lat25 <= 1'b0;
            if (ba_i == '0 && addr_i[6:4] == CL_CODE_25) lat25 <= 1'b1;
          end
          PINS_ACT: if (mrs_age < MODE_SET_GAP - 1) viol_o++;
          PINS_WRITE: begin
            if (bst_age < (lat25 ? BURST_STOP_TO_WRITE_CL25 : BURST_STOP_TO_WRITE_CL2) - 1)
              viol_o++;
            if (rd_age < (lat25 ? READ_TO_WRITE_BASE_CL25 : READ_TO_WRITE_BASE_CL2) + half - 1)
              viol_o++;
            wr_age <= 8'h00;
            wr_bank <= ba_i;
          end
          PINS_READ: begin
            if (wr_age < WRITE_TO_READ_BASE + half - 1) viol_o++;
            if (sr_age < SELFREFRESH_EXIT_READ_GAP - 1) viol_o++;
            {rd_age, stop_age, rd_bank, col} <= {8'h00, 8'hFF, ba_i, addr_i[7:0]};
          end
          PINS_PRE: begin
            if (ba_i == wr_bank && wr_age < WRITE_TO_PRECHARGE_BASE + half - 1) viol_o++;
            if (ba_i == rd_bank && rd_age < half - 1) viol_o++;
            stop_age <= 8'(rd_age + cap);
          end
          PINS_BST: begin
            bst_age <= 8'h00;
            stop_age <= 8'(rd_age + cap);
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the ddr command host against the module model
`timescale 1ns/10ps
`default_nettype none
module testbench
  import ddr_timing_pkg::*;
;
  typedef struct {op_t op; logic [1:0] b; logic [12:0] a; pins_t p;} row_t;
  typedef struct packed {logic [15:0] d; logic [1:0] m;} wbeat_t;
  logic clk_i, rst_n_i, cmd_valid_i, wd_valid_i, cmd_ready_o, wd_ready_o, rd_valid_o;
  logic cke_o, dq_oe_o, wseen;
  user_cmd_t cmd_i;
  pins_t cmd_pins_o;
  logic [15:0] wd_data_i, rd_data_o, dq_o, dq_dev, bus, beat, k;
  logic [1:0] wd_mask_i, dm_o, mask, ba_o;
  logic [12:0] addr_o;
  int viol, err_count, n_tests, cyc, t_seen, half;
  wbeat_t wq[$], exp_wr[$];
  logic [15:0] exp_rd[$];
  row_t rows[] = '{
    '{OP_MRS, 2'h0, 13'h0022, PINS_MRS},
    '{OP_ACT, 2'h1, 13'h0010, PINS_ACT},
    '{OP_WRITE, 2'h1, 13'h0020, PINS_WRITE},
    '{OP_READ, 2'h1, 13'h0024, PINS_READ},
    '{OP_WRITE, 2'h1, 13'h0028, PINS_WRITE},
    '{OP_PRE, 2'h1, 13'h0000, PINS_PRE},
    '{OP_ACT, 2'h2, 13'h0011, PINS_ACT},
    '{OP_READ, 2'h2, 13'h0030, PINS_READ},
    '{OP_PRE, 2'h2, 13'h0000, PINS_PRE},
    '{OP_BST, 2'h2, 13'h0000, PINS_BST},
    '{OP_WRITE, 2'h2, 13'h0034, PINS_WRITE},
    '{OP_MRS, 2'h0, 13'h0061, PINS_MRS},
    '{OP_MRS, 2'h0, 13'h0061, PINS_MRS},
    '{OP_ACT, 2'h0, 13'h0012, PINS_ACT},
    '{OP_READ, 2'h0, 13'h0040, PINS_READ},
    '{OP_WRITE, 2'h0, 13'h0044, PINS_WRITE},
    '{OP_PRE, 2'h0, 13'h0000, PINS_PRE},
    '{OP_REF, 2'h0, 13'h0000, PINS_REF}
  };
  assign bus = dq_oe_o ? dq_o : dq_dev;
  ddr_cmd_host #(.DQ_W(8)) i_ddr_cmd_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .wd_valid_i(wd_valid_i), .wd_data_i(wd_data_i), .wd_mask_i(wd_mask_i),
    .wd_ready_o(wd_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .cke_o(cke_o),
    .cmd_pins_o(cmd_pins_o), .ba_o(ba_o), .addr_o(addr_o), .dq_i(bus), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .dm_o(dm_o));
  ddr_dimm_model #(.DQ_W(8)) i_ddr_dimm_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cke_i(cke_o), .pins_i(cmd_pins_o), .ba_i(ba_o), .addr_i(addr_o), .bus_i(bus),
    .oe_i(dq_oe_o), .dm_i(dm_o), .dq_o(dq_dev), .seen_o(wseen), .beat_o(beat),
    .mask_o(mask), .viol_o(viol));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic push_beat();
    wq.push_back('{16'hA000 + k, k[1:0]});
    exp_wr.push_back('{16'hA000 + k, k[1:0]});
    k++;
  endtask
  task automatic issue(input op_t op, input logic [1:0] b, input logic [12:0] a,
                       input pins_t p, input logic kc);
    int n;
    logic k0;
    n = 0;
    k0 = cke_o;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= '{op, b, a};
    do @(posedge clk_i); while (cmd_ready_o !== 1'b1 && ++n < 400);
    cmd_valid_i <= 1'b0;
    while (cmd_pins_o === PINS_NOP && cke_o === k0 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    t_seen = cyc;
    check(cmd_pins_o, p);
    check(cke_o, kc);
    if (p != PINS_NOP) check({ba_o, addr_o}, {b, a});
    if (op == OP_READ) for (int j = 0; j < half; j++) exp_rd.push_back({a[7:0], 8'(j)});
  endtask
  // ----------------------------------------------------------------
  // stimulus and monitors
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (wd_valid_i && wd_ready_o) void'(wq.pop_front());
    wd_valid_i <= (wq.size() > 0);
    if (wq.size() > 0) {wd_data_i, wd_mask_i} <= wq[0];
    if (rd_valid_o === 1'b1) begin
      if (exp_rd.size() == 0) check(1, 0);
      else check(rd_data_o, exp_rd.pop_front());
    end
    if (wseen === 1'b1) begin
      if (exp_wr.size() == 0) check(1, 0);
      else check({beat, mask}, exp_wr.pop_front());
    end
  end
  // generous bound: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    report_and_stop();
  end
  initial begin
    int n, t0;
    {rst_n_i, cmd_valid_i, wd_valid_i, wd_data_i, wd_mask_i} = '0;
    cmd_i = '0;
    {err_count, n_tests, cyc, k} = '0;
    half = 4;
    repeat (20) @(posedge clk_i);
    check({cke_o, cmd_pins_o, dq_oe_o, dm_o, cmd_ready_o, wd_ready_o}, 10'h2EF);
    rst_n_i <= 1'b1;
    // three beats into a two-entry buffer: it must refuse the third
    repeat (3) push_beat();
    repeat (6) @(posedge clk_i);
    check(wd_ready_o, 1'b0);
    foreach (rows[i]) begin
      n = 0;
      while (rows[i].op == OP_BST && exp_rd.size() > 0 && n++ < 100) @(posedge clk_i);
      if (rows[i].op == OP_WRITE) for (int j = 0; j < half; j++) push_beat();
      if (rows[i].op == OP_MRS) half = (rows[i].a[2:0] == BL_CODE_2) ? 1 :
                                       (rows[i].a[2:0] == BL_CODE_4) ? 2 : 4;
      issue(rows[i].op, rows[i].b, rows[i].a, rows[i].p, 1'b1);
    end
    issue(OP_SREF_IN, 2'h0, 13'h0000, PINS_REF, 1'b0);
    issue(OP_LP_EXIT, 2'h0, 13'h0000, PINS_NOP, 1'b1);
    t0 = t_seen;
    issue(OP_ACT, 2'h3, 13'h0013, PINS_ACT, 1'b1);
    check(t_seen - t0 >= SELFREFRESH_EXIT_NONREAD_GAP, 1);
    issue(OP_READ, 2'h3, 13'h0050, PINS_READ, 1'b1);
    check(t_seen - t0 >= SELFREFRESH_EXIT_READ_GAP, 1);
    issue(OP_PDOWN_IN, 2'h0, 13'h0000, PINS_NOP, 1'b0);
    issue(OP_LP_EXIT, 2'h0, 13'h0000, PINS_NOP, 1'b1);
    t0 = t_seen;
    issue(OP_PRE, 2'h3, 13'h0000, PINS_PRE, 1'b1);
    check(t_seen - t0 >= POWERDOWN_EXIT_GAP, 1);
    repeat (30) @(posedge clk_i);
    check(exp_rd.size(), 0);
    check(exp_wr.size(), 3);
    check(viol, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
